/* File: common/exec_pkg.sv */
package exec_pkg;
	// ----------------------------------------
	// instruction encodings
	// ----------------------------------------
	localparam logic [5:0]  ROT_OPC     = 6'h10;   // 0100 00 d a f
	localparam logic [6:0]  SET_OPC     = 7'h34;   // 0110 100 a f
	localparam logic [15:0] SLEEP_WORD  = 16'h0003;
	localparam int          ROT_HI      = 15;
	localparam int          ROT_LO      = 10;
	localparam int          SET_LO      = 9;
	localparam int          DEST_BIT    = 9;
	localparam int          ACC_BIT     = 8;
	// ----------------------------------------
	// data constants
	// ----------------------------------------
	localparam logic [7:0]  ALL_ONES    = 8'hff;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;
	localparam logic [3:0]  ACCESS_BANK = 4'h0;
	localparam logic [1:0]  PHASE_LAST  = 2'h3;
	// ----------------------------------------
	// quarter phases, gray ordered
	// ----------------------------------------
	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b11,
		Q4 = 2'b10
	} phase_t;
	// decoded operation
	typedef enum logic [1:0] {
		OP_NONE  = 2'h0,
		OP_ROT   = 2'h1,
		OP_SET   = 2'h2,
		OP_SLEEP = 2'h3
	} op_t;
endpackage

/* File: common/dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
// decoded instruction fields passed from decoder to executor
interface dec_if;
	exec_pkg::op_t op;        // which operation
	logic          dest_file; // destination select
	logic          use_bank;  // access select
	logic [7:0]    faddr;     // file address low byte
	modport dec (output op, output dest_file, output use_bank, output faddr);
	modport exe (input op, input dest_file, input use_bank, input faddr);
endinterface
`default_nettype wire

/* File: rtl/instr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// pure combinational opcode decoder
// ----------------------------------------
module instr_decode (
	// fetched word
	input  wire logic [15:0] word,
	// decoded fields
	dec_if.dec               d
);
	always_comb begin
		d.dest_file = word[exec_pkg::DEST_BIT];
		d.use_bank  = word[exec_pkg::ACC_BIT];
		d.faddr     = word[7:0];
		if (word[exec_pkg::ROT_HI:exec_pkg::ROT_LO] == exec_pkg::ROT_OPC) begin
			d.op = exec_pkg::OP_ROT;
		end else if (word[exec_pkg::ROT_HI:exec_pkg::SET_LO] == exec_pkg::SET_OPC) begin
			d.op = exec_pkg::OP_SET;
		end else if (word == exec_pkg::SLEEP_WORD) begin
			d.op = exec_pkg::OP_SLEEP;
		end else begin
			d.op = exec_pkg::OP_NONE;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/rot_set_sleep.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - rotate is one word, one cycle, Q1..Q4
// - access bit 1 uses bank select register
// - destination 0 writes working register only
// - destination 1 writes rotated value to file
// - set-all writes 0xff to file register
// - sleep clears power-down, sets time-out flag
// - sleep clears watchdog count and postscaler
// - sleep halts oscillator, enters low power
// - watchdog wake clears time-out flag
// - rotate right, old bit0 into bit7
// - rotate opcode 0100 00 d a f
// - access bit 0 uses fixed access bank
module rot_set_sleep (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// instruction stream, sampled at Q1
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	// file register read port, data sampled in the same cycle as the address
	input  wire logic [7:0]  file_rdata,
	// bank select register contents
	input  wire logic [3:0]  bank_select_register,
	// wake sources (from outside the clock domain)
	input  wire logic        wake_wdt,
	input  wire logic        wake_other,
	// file register access
	output logic      [11:0] file_addr,
	output logic      [7:0]  file_wdata,
	output logic             file_we,
	// working register
	output logic      [7:0]  w_ff,
	// status flags
	output logic             neg_flag,
	output logic             zero_flag,
	output logic             power_down_flag,
	output logic             time_out_flag,
	// watchdog and oscillator control
	output logic             wdt_clear,
	output logic             osc_stop,
	output logic             sleeping
);
	// ----------------------------------------
	// wake synchronisers
	// ----------------------------------------
	logic wdt_s1_ff, wdt_s2_ff;   // watchdog wake chain
	logic oth_s1_ff, oth_s2_ff;   // other wake chain
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdt_s1_ff <= 1'b0;
			wdt_s2_ff <= 1'b0;
			oth_s1_ff <= 1'b0;
			oth_s2_ff <= 1'b0;
		end else begin
			wdt_s1_ff <= wake_wdt;
			wdt_s2_ff <= wdt_s1_ff;
			oth_s1_ff <= wake_other;
			oth_s2_ff <= oth_s1_ff;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	dec_if dq ();
	instr_decode u_dec (
		.word (instr_word),
		.d    (dq)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	exec_pkg::phase_t phase_ff, nxt_phase;  // quarter phase
	exec_pkg::op_t    op_ff, nxt_op;        // latched operation
	logic             dest_ff, nxt_dest;    // destination select
	logic [11:0]      addr_ff, nxt_addr;    // full file address
	logic [7:0]       opnd_ff, nxt_opnd;    // operand read in Q2
	logic [7:0]       res_ff, nxt_res;      // result built in Q3
	logic [7:0]       nxt_w, nxt_wdata;
	logic             nxt_we, nxt_n, nxt_z, nxt_pd, nxt_to;
	logic             nxt_wclr, nxt_stop, nxt_sleep;
	logic             fetch_ok;             // core advances only when awake

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		fetch_ok  = !sleeping;
		nxt_phase = phase_ff;
		nxt_op    = op_ff;
		nxt_dest  = dest_ff;
		nxt_addr  = addr_ff;
		nxt_opnd  = opnd_ff;
		nxt_res   = res_ff;
		nxt_w     = w_ff;
		nxt_wdata = file_wdata;
		nxt_we    = 1'b0;          // write strobe is a single cycle
		nxt_n     = neg_flag;
		nxt_z     = zero_flag;
		nxt_pd    = power_down_flag;
		nxt_to    = time_out_flag;
		nxt_wclr  = 1'b0;
		nxt_stop  = osc_stop;
		nxt_sleep = sleeping;
		if (sleeping) begin
			// oscillator stopped: only a wake source restarts the core
			if (wdt_s2_ff) begin
				nxt_to    = 1'b0;
				nxt_sleep = 1'b0;
				nxt_stop  = 1'b0;
			end else if (oth_s2_ff) begin
				nxt_sleep = 1'b0;
				nxt_stop  = 1'b0;
			end
		end else if (fetch_ok) begin
			case (phase_ff)
				exec_pkg::Q1: begin
					// decode and form the address
					nxt_op   = instr_valid ? dq.op : exec_pkg::OP_NONE;
					nxt_dest = dq.dest_file;
					if (dq.use_bank) begin
						nxt_addr = {bank_select_register, dq.faddr};
					end else begin
						nxt_addr = {exec_pkg::ACCESS_BANK, dq.faddr};
					end
					nxt_phase = exec_pkg::Q2;
				end
				exec_pkg::Q2: begin
					// read the operand; sleep performs no read
					if (op_ff != exec_pkg::OP_SLEEP) begin
						nxt_opnd = file_rdata;
					end
					nxt_phase = exec_pkg::Q3;
				end
				exec_pkg::Q3: begin
					if (op_ff == exec_pkg::OP_ROT) begin
						nxt_res = {opnd_ff[0], opnd_ff[7:1]};
					end else if (op_ff == exec_pkg::OP_SET) begin
						nxt_res = exec_pkg::ALL_ONES;
					end
					nxt_phase = exec_pkg::Q4;
				end
				default: begin
					// Q4: write destination
					if (op_ff == exec_pkg::OP_ROT) begin
						if (dest_ff) begin
							nxt_wdata = res_ff;
							nxt_we    = 1'b1;
						end else begin
							nxt_w = res_ff;
						end
						nxt_n = res_ff[7];
						nxt_z = (res_ff == exec_pkg::ZERO_BYTE);
					end else if (op_ff == exec_pkg::OP_SET) begin
						// flags untouched
						nxt_wdata = res_ff;
						nxt_we    = 1'b1;
					end else if (op_ff == exec_pkg::OP_SLEEP) begin
						nxt_pd    = 1'b0;
						nxt_to    = 1'b1;
						nxt_wclr  = 1'b1;
						nxt_stop  = 1'b1;
						nxt_sleep = 1'b1;
					end
					nxt_phase = exec_pkg::Q1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_ff        <= exec_pkg::Q1;
			op_ff           <= exec_pkg::OP_NONE;
			dest_ff         <= 1'b0;
			addr_ff         <= 12'h000;
			opnd_ff         <= 8'h00;
			res_ff          <= 8'h00;
			w_ff            <= 8'h00;
			file_wdata      <= 8'h00;
			file_we         <= 1'b0;
			neg_flag        <= 1'b0;
			zero_flag       <= 1'b0;
			power_down_flag <= 1'b1;   // power-on: both status bits set
			time_out_flag   <= 1'b1;
			wdt_clear       <= 1'b0;
			osc_stop        <= 1'b0;
			sleeping        <= 1'b0;
		end else begin
			phase_ff        <= nxt_phase;
			op_ff           <= nxt_op;
			dest_ff         <= nxt_dest;
			addr_ff         <= nxt_addr;
			opnd_ff         <= nxt_opnd;
			res_ff          <= nxt_res;
			w_ff            <= nxt_w;
			file_wdata      <= nxt_wdata;
			file_we         <= nxt_we;
			neg_flag        <= nxt_n;
			zero_flag       <= nxt_z;
			power_down_flag <= nxt_pd;
			time_out_flag   <= nxt_to;
			wdt_clear       <= nxt_wclr;
			osc_stop        <= nxt_stop;
			sleeping        <= nxt_sleep;
		end
	end

	// address register is the output flip-flop itself
	assign file_addr = addr_ff;
endmodule
`default_nettype wire

/* File: bench/file_regs_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// file register array beside the block
// ----------------------------------------
module file_regs_model (
	// clock
	input  wire logic        clk,
	// access from the block
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        we,
	output logic      [7:0]  rdata
);
	logic [7:0] mem [4096]; // contents, preloaded by the bench
	// read is combinational: data stands as long as the address does
	assign rdata = mem[addr];
	// a write lands at the edge that closes the strobe cycle
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end
endmodule
`default_nettype wire

/* File: bench/rot_set_sleep_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// checks on the executor ports
// ----------------------------------------
module rot_set_sleep_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// instruction and file port
	input wire logic [15:0] instr_word,
	input wire logic [7:0]  file_rdata,
	input wire logic [3:0]  bank_select_register,
	input wire logic [11:0] file_addr,
	input wire logic [7:0]  file_wdata,
	input wire logic        file_we,
	// flags and power control
	input wire logic        neg_flag,
	input wire logic        zero_flag,
	input wire logic        power_down_flag,
	input wire logic        time_out_flag,
	input wire logic        wdt_clear,
	input wire logic        osc_stop,
	input wire logic        sleeping
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// a write is seen four edges after its word was taken at q1
	pulse_once_a: assert property (file_we |=> !file_we) else $error("write strobe too long");
	file_addr_a: assert property (file_we |-> file_addr ==
		{($past(instr_word[8],4) ? $past(bank_select_register,4) : exec_pkg::ACCESS_BANK), $past(instr_word[7:0],4)})
		else $error("write address wrong");
	rot_value_a: assert property (file_we && $past(instr_word[15:10],4) == exec_pkg::ROT_OPC |->
		file_wdata == {$past(file_rdata[0],3), $past(file_rdata[7:1],3)}) else $error("rotate result wrong");
	set_value_a: assert property (file_we && $past(instr_word[15:9],4) == exec_pkg::SET_OPC |->
		file_wdata == exec_pkg::ALL_ONES) else $error("set value wrong");
	set_flags_a: assert property (file_we && $past(instr_word[15:9],4) == exec_pkg::SET_OPC |->
		$stable(neg_flag) && $stable(zero_flag)) else $error("set moved a flag");
	sleep_entry_a: assert property (wdt_clear |->
		sleeping && osc_stop && !power_down_flag && time_out_flag) else $error("sleep entry wrong");
	sleep_cause_a: assert property ($rose(sleeping) |-> wdt_clear) else $error("sleep without clear");
	asleep_quiet_a: assert property (sleeping |-> osc_stop && !file_we) else $error("activity asleep");
	wdt_wake_a: assert property ($fell(time_out_flag) |-> $fell(sleeping)) else $error("time-out dropped");
	cover property (file_we);
	cover property (wdt_clear);
	cover property ($fell(time_out_flag));
endmodule
bind rot_set_sleep rot_set_sleep_asserts u_chk (.clk(clk), .nrst(nrst), .instr_word(instr_word),
	.file_rdata(file_rdata), .bank_select_register(bank_select_register), .file_addr(file_addr),
	.file_wdata(file_wdata), .file_we(file_we), .neg_flag(neg_flag), .zero_flag(zero_flag),
	.power_down_flag(power_down_flag), .time_out_flag(time_out_flag), .wdt_clear(wdt_clear),
	.osc_stop(osc_stop), .sleeping(sleeping));
`default_nettype wire

/* File: bench/rot_set_sleep_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rot_set_sleep_tb;
	logic        clk, nrst, vld, wwdt, woth, we, neg, zero, pd, to, wclr, osc, slp;
	logic [15:0] word;
	logic [3:0]  bank;
	logic [7:0]  rdata, wdata, w;
	logic [11:0] addr;
	int          bad_count, checked;
	rot_set_sleep DUT (.clk(clk), .nrst(nrst), .instr_word(word), .instr_valid(vld), .file_rdata(rdata),
		.bank_select_register(bank), .wake_wdt(wwdt), .wake_other(woth), .file_addr(addr), .file_wdata(wdata),
		.file_we(we), .w_ff(w), .neg_flag(neg), .zero_flag(zero), .power_down_flag(pd), .time_out_flag(to),
		.wdt_clear(wclr), .osc_stop(osc), .sleeping(slp));
	file_regs_model mdl (.clk(clk), .addr(addr), .wdata(wdata), .we(we), .rdata(rdata));
	// 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one word per eight cycles; returns at the edge closing the result cycle
	task automatic exec(input logic [15:0] x);
		repeat (3) @(posedge clk);
		word <= x;
		vld  <= 1'b1;
		@(posedge clk);
		vld <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic rot(input logic d, a, input logic [3:0] b, input logic [7:0] f, v);
		logic [7:0] r;
		r = {v[0], v[7:1]};
		bank <= b;
		mdl.mem[{(a ? b : 4'h0), f}] = v;
		exec({exec_pkg::ROT_OPC, d, a, f});
		chk(addr, {(a ? b : exec_pkg::ACCESS_BANK), f});
		chk(we, d);
		chk(d ? wdata : w, r);
		chk({neg, zero}, {r[7], r == 8'h00});
	endtask
	task automatic t_rotates;
		rot(1'b1, 1'b0, 4'h5, 8'h20, 8'hd7);
		rot(1'b0, 1'b1, 4'h5, 8'h20, 8'hd7);
		rot(1'b1, 1'b1, 4'ha, 8'hff, 8'h01);
		rot(1'b0, 1'b0, 4'h3, 8'h00, 8'h00);
		$display("rotate test done");
	endtask
	// rotate-left word is not ours: nothing may move
	task automatic t_nop;
		// nonzero operand, so a misdecoded rotate would move w and the flags
		mdl.mem[12'h000] = 8'h81;
		exec(16'h4400);
		chk({we, w, neg, zero}, 11'h001);
		// landed writes and the unwritten d=0 target; a replay with valid low would have rotated 020 and aff again
		chk(mdl.mem[12'h020], 8'heb);
		chk(mdl.mem[12'h520], 8'hd7);
		chk(mdl.mem[12'haff], 8'h80);
		$display("nop test done");
	endtask
	task automatic t_set;
		bank <= 4'hc;
		mdl.mem[12'hc7e] = 8'h5a;
		exec({exec_pkg::SET_OPC, 1'b1, 8'h7e});
		chk(addr, 12'hc7e);
		chk({we, wdata}, {1'b1, exec_pkg::ALL_ONES});
		chk({neg, zero}, 2'b01);
		// the write lands at the closing edge; look once it has settled
		@(negedge clk);
		chk(mdl.mem[12'hc7e], exec_pkg::ALL_ONES);
		$display("set test done");
	endtask
	// hold the word until it is taken, since phase after a wake is not known
	task automatic t_sleep(input logic by_wdt);
		int   n;
		logic clr;
		clr = 1'b0;
		// one edge of gap: a back-to-back call must not re-raise valid in the step that lowered it
		@(posedge clk);
		word <= exec_pkg::SLEEP_WORD;
		vld  <= 1'b1;
		for (n = 0; n < 20 && slp !== 1'b1; n++) begin
			@(posedge clk);
			clr = clr | (wclr === 1'b1);
		end
		if (n == 20) begin
			bad_count++;
			conclude;
		end
		chk({pd, to, osc, clr}, 4'h7);
		word <= {exec_pkg::SET_OPC, 1'b0, 8'h10};
		repeat (8) @(posedge clk);
		chk({slp, we}, 2'b10);
		wwdt <= by_wdt;
		woth <= !by_wdt;
		for (n = 0; n < 10 && slp !== 1'b0; n++) begin
			@(posedge clk);
		end
		if (n == 10) begin
			bad_count++;
			conclude;
		end
		chk(to, !by_wdt);
		wwdt <= 1'b0;
		woth <= 1'b0;
		vld  <= 1'b0;
		$display("sleep test done");
	endtask
	initial begin
		nrst = 1'b0;
		vld = 1'b0;
		wwdt = 1'b0;
		woth = 1'b0;
		word = 16'h0000;
		bank = 4'h0;
		bad_count = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk({pd, to}, 2'b11);
		t_rotates;
		t_nop;
		t_set;
		t_sleep(1'b0);
		t_sleep(1'b1);
		conclude;
	end
endmodule
`default_nettype wire
